/* File: src/hir_result_regs.sv */
// high-resolution result registers: offset, divider config, result bytes, flags
// Operation
// - 16-bit offset from low and high bytes, subtracted from each result.
// - two-bit divider field divides sensor frequency by 1, 2, 4 or 8.
// - 24-bit result spread over three read-only byte registers.
// - zero-offset code is fsensor times 2^24 over fref over 2^div.
// - all six registers reset to zero; result registers ignore writes.
// - active-low ready flag drops at conversion end, rises on low-byte read.
// - error flags become visible only after a low-byte read.
// - conversion lasts reference count times 16 plus 55 reference cycles.
`timescale 1ns/100ps
module hir_result_regs import hir_pkg::*; (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  input wire logic sensor_edge,
  input wire logic [HIR_REFERENCE_COUNT_W-1:0] reference_count,
  output logic conv_done,
  output logic hires_result_pending_n,
  output logic zero_cycles_error,
  output logic over_range_error,
  output logic under_range_error,
  output logic overflow_error
);

  typedef struct packed {
    logic [15:0] hires_offset_value;
    logic [7:0] cfg;
    logic [HIR_CODE_W-1:0] hires_result_code;
    logic [15:0] hold;
    logic [3:0] err_pend;
    logic [3:0] err_vis;
    logic pending_n;
    logic [7:0] rdata;
    logic done;
  } hir_regs_s;

  hir_regs_s regs_reg;
  hir_regs_s regs_next;

  hir_conv_if conv ();

  logic [HIR_CODE_W:0] diff;
  logic neg;
  logic rd_low;

  // divider field steers the sensor prescaler
  assign conv.div_sel = regs_reg.cfg[HIR_DIV_MSB:HIR_DIV_LSB];
  // reference count feeds the window timer
  assign conv.reference_count = reference_count;

  hir_conv_timer u_timer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sensor_edge(sensor_edge),
    .conv(conv.timer)
  );

  // subtract offset; borrow means negative code
  assign diff = {1'b0, conv.raw_code} - {9'h000, regs_reg.hires_offset_value};
  assign neg = diff[HIR_CODE_W];
  assign rd_low = reg_rd_en && (reg_addr == HIR_ADDR_RESULT_LOW);

  // next state of the register file
  always_comb begin
    regs_next = regs_reg;
    regs_next.done = 1'b0;

    // register reads; data is returned one cycle after the strobe
    if (reg_rd_en) begin
      case (reg_addr)
        HIR_ADDR_OFFSET_LOW: regs_next.rdata = regs_reg.hires_offset_value[7:0];
        HIR_ADDR_OFFSET_HIGH: regs_next.rdata = regs_reg.hires_offset_value[15:8];
        HIR_ADDR_CONFIG: regs_next.rdata = regs_reg.cfg;
        // low byte from live result, upper bytes from the snapshot
        HIR_ADDR_RESULT_LOW: regs_next.rdata = regs_reg.hires_result_code[7:0];
        HIR_ADDR_RESULT_MIDDLE: regs_next.rdata = regs_reg.hold[7:0];
        HIR_ADDR_RESULT_HIGH: regs_next.rdata = regs_reg.hold[15:8];
        default: regs_next.rdata = HIR_UNMAPPED_DATA;
      endcase
    end

    // snapshot upper bytes so the sequence stays coherent
    if (rd_low) begin
      regs_next.hold = regs_reg.hires_result_code[HIR_CODE_W-1:8];
      // publish the errors of the result just read
      regs_next.err_vis = regs_reg.err_pend;
      // reading the low byte releases the ready flag
      regs_next.pending_n = 1'b1;
    end

    // only offset and config take writes; results ignore them
    if (reg_wr_en) begin
      case (reg_addr)
        HIR_ADDR_OFFSET_LOW: regs_next.hires_offset_value[7:0] = reg_wdata;
        HIR_ADDR_OFFSET_HIGH: regs_next.hires_offset_value[15:8] = reg_wdata;
        // upper bits stored as written, no masking
        HIR_ADDR_CONFIG: regs_next.cfg = reg_wdata;
        default: begin
        end
      endcase
    end

    // new conversion; placed last so it wins over a same-cycle low read
    if (conv.conv_done) begin
      // clamp a negative code to zero and flag it
      regs_next.hires_result_code = neg ? HIR_RST_RESULT : diff[HIR_CODE_W-1:0];
      regs_next.err_pend[HIR_ZERO_CYCLES_ERROR] = conv.raw_zero;
      regs_next.err_pend[HIR_ERR_OR] = conv.raw_over_range;
      regs_next.err_pend[HIR_UNDER_RANGE_ERROR] = neg && !conv.raw_zero && !conv.raw_over_range;
      regs_next.err_pend[HIR_OVERFLOW_ERROR] = conv.raw_overflow;
      // ready flag drops at conversion end
      regs_next.pending_n = 1'b0;
      regs_next.done = 1'b1;
    end
  end

  // state register, everything zero after reset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regs_reg.hires_offset_value <= HIR_RST_OFFSET;
      regs_reg.cfg <= HIR_RST_BYTE;
      regs_reg.hires_result_code <= HIR_RST_RESULT;
      regs_reg.hold <= HIR_RST_OFFSET;
      regs_reg.err_pend <= 4'h0;
      regs_reg.err_vis <= 4'h0;
      regs_reg.pending_n <= HIR_RST_PENDING_N;
      regs_reg.rdata <= HIR_RST_BYTE;
      regs_reg.done <= 1'b0;
    end else begin
      regs_reg <= regs_next;
    end
  end

  // outputs, all straight from the state register
  assign reg_rdata = regs_reg.rdata;
  assign conv_done = regs_reg.done;
  assign hires_result_pending_n = regs_reg.pending_n;
  assign zero_cycles_error = regs_reg.err_vis[HIR_ZERO_CYCLES_ERROR];
  assign over_range_error = regs_reg.err_vis[HIR_ERR_OR];
  assign under_range_error = regs_reg.err_vis[HIR_UNDER_RANGE_ERROR];
  assign overflow_error = regs_reg.err_vis[HIR_OVERFLOW_ERROR];
endmodule

/* File: src/hir_pkg.sv */
// shared constants and types for the high-resolution result register block
package hir_pkg;
  // register addresses on the internal register port
  localparam logic [7:0] HIR_ADDR_OFFSET_LOW = 8'h32;
  localparam logic [7:0] HIR_ADDR_OFFSET_HIGH = 8'h33;
  localparam logic [7:0] HIR_ADDR_CONFIG = 8'h34;
  localparam logic [7:0] HIR_ADDR_RESULT_LOW = 8'h38;
  localparam logic [7:0] HIR_ADDR_RESULT_MIDDLE = 8'h39;
  localparam logic [7:0] HIR_ADDR_RESULT_HIGH = 8'h3A;

  // reset values
  localparam logic [7:0] HIR_RST_BYTE = 8'h00;
  localparam logic [15:0] HIR_RST_OFFSET = 16'h0000;
  localparam logic [23:0] HIR_RST_RESULT = 24'h00_0000;
  // data-ready flag reads zero out of reset
  localparam logic HIR_RST_PENDING_N = 1'b0;
  // value returned for unmapped addresses
  localparam logic [7:0] HIR_UNMAPPED_DATA = 8'h00;

  // config field layout
  localparam int HIR_DIV_LSB = 0;
  localparam int HIR_DIV_MSB = 1;

  // conversion timing: window = reference_count * mul + add reference cycles
  localparam int HIR_CONV_MUL = 16;
  localparam int HIR_CONV_ADD = 55;
  localparam int HIR_REFERENCE_COUNT_W = 16;
  localparam int HIR_WIN_W = 21;
  localparam int HIR_CODE_W = 24;
  localparam int HIR_QBIT_W = 5;

  // error flag positions inside a 4-bit error vector
  localparam int HIR_ZERO_CYCLES_ERROR = 3;
  localparam int HIR_ERR_OR = 2;
  localparam int HIR_UNDER_RANGE_ERROR = 1;
  localparam int HIR_OVERFLOW_ERROR = 0;

  // sensor divider settings
  typedef enum logic [1:0] {
    HIR_DIV_BY1,
    HIR_DIV_BY2,
    HIR_DIV_BY4,
    HIR_DIV_BY8
  } hir_div_e;
endpackage

/* File: src/hir_conv_if.sv */
// link between the register block and the conversion timer
`timescale 1ns/100ps
interface hir_conv_if;
  logic [1:0] div_sel;
  logic [15:0] reference_count;
  logic conv_done;
  logic [23:0] raw_code;
  logic raw_zero;
  logic raw_over_range;
  logic raw_overflow;

  modport timer (
    input div_sel,
    input reference_count,
    output conv_done,
    output raw_code,
    output raw_zero,
    output raw_over_range,
    output raw_overflow
  );

  modport regs (
    output div_sel,
    output reference_count,
    input conv_done,
    input raw_code,
    input raw_zero,
    input raw_over_range,
    input raw_overflow
  );
endinterface

/* File: src/hir_conv_timer.sv */
// conversion window timer, sensor divider and code divider
`timescale 1ns/100ps
module hir_conv_timer import hir_pkg::*; (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic sensor_edge,
  hir_conv_if.timer conv
);

  typedef enum logic {
    HIR_ST_COUNT,
    HIR_ST_DIVIDE
  } hir_tstate_e;

  typedef struct packed {
    hir_tstate_e st;
    logic [HIR_WIN_W-1:0] win_cnt;
    logic [HIR_WIN_W-1:0] edge_cnt;
    logic [2:0] presc;
    logic [HIR_WIN_W-1:0] den;
    logic [HIR_WIN_W:0] rem;
    logic [HIR_CODE_W-1:0] quot;
    logic [HIR_QBIT_W-1:0] bit_cnt;
    logic done;
    logic [HIR_CODE_W-1:0] code;
    logic zc;
    logic ovr;
    logic ovf;
  } hir_timer_s;

  hir_timer_s timer_reg;
  hir_timer_s timer_next;

  logic [HIR_WIN_W-1:0] win_len;
  logic [2:0] presc_mask;
  logic div_edge;
  logic [HIR_WIN_W-1:0] edge_final;
  logic [HIR_WIN_W:0] rem_shift;

  assign win_len = HIR_WIN_W'({5'h0, conv.reference_count} * HIR_CONV_MUL) + HIR_WIN_W'(HIR_CONV_ADD);

  assign presc_mask = 3'((4'h1 << conv.div_sel) - 4'h1);
  assign div_edge = sensor_edge && ((timer_reg.presc & presc_mask) == presc_mask);
  assign edge_final = timer_reg.edge_cnt + HIR_WIN_W'(div_edge);
  assign rem_shift = {timer_reg.rem[HIR_WIN_W-1:0], 1'b0};

  // next state: count the window, then long-divide edges * 2^24 by its length
  always_comb begin
    timer_next = timer_reg;
    timer_next.done = 1'b0;
    if (sensor_edge) begin
      timer_next.presc = timer_reg.presc + 3'h1;
    end
    timer_next.edge_cnt = edge_final;
    timer_next.win_cnt = timer_reg.win_cnt + HIR_WIN_W'(1);
    // >= so that a shrinking reference count still closes the window
    if (timer_reg.win_cnt >= win_len - HIR_WIN_W'(1)) begin
      timer_next.win_cnt = '0;
      timer_next.edge_cnt = '0;
      timer_next.den = win_len;
      timer_next.zc = (edge_final == '0);
      timer_next.ovr = (edge_final > win_len);
      timer_next.ovf = (edge_final == win_len);
      if ((edge_final == '0) || (edge_final >= win_len)) begin
        // no edges, or code would not fit in 24 bits: report at once with zero code
        timer_next.code = '0;
        timer_next.done = 1'b1;
      end else begin
        timer_next.rem = {1'b0, edge_final};
        timer_next.quot = '0;
        timer_next.bit_cnt = HIR_QBIT_W'(HIR_CODE_W);
        timer_next.st = HIR_ST_DIVIDE;
      end
    end
    // one quotient bit per cycle, 24 cycles, shorter than any window
    case (timer_reg.st)
      HIR_ST_COUNT: begin
      end
      HIR_ST_DIVIDE: begin
        if (rem_shift >= {1'b0, timer_reg.den}) begin
          timer_next.rem = rem_shift - {1'b0, timer_reg.den};
          timer_next.quot = {timer_reg.quot[HIR_CODE_W-2:0], 1'b1};
        end else begin
          timer_next.rem = rem_shift;
          timer_next.quot = {timer_reg.quot[HIR_CODE_W-2:0], 1'b0};
        end
        timer_next.bit_cnt = timer_reg.bit_cnt - HIR_QBIT_W'(1);
        if (timer_reg.bit_cnt == HIR_QBIT_W'(1)) begin
          timer_next.code = timer_next.quot;
          timer_next.done = 1'b1;
          timer_next.st = HIR_ST_COUNT;
        end
      end
      default: begin
        timer_next.st = HIR_ST_COUNT;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_reg <= '0;
    end else begin
      timer_reg <= timer_next;
    end
  end

  // results toward the register block
  assign conv.conv_done = timer_reg.done;
  assign conv.raw_code = timer_reg.code;
  assign conv.raw_zero = timer_reg.zc;
  assign conv.raw_over_range = timer_reg.ovr;
  assign conv.raw_overflow = timer_reg.ovf;
endmodule

/* File: bench/hir_result_checker.sv */
// port assertions for the result register block
`timescale 1ns/100ps
module hir_result_checker import hir_pkg::*; (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rdata,
  input wire logic [15:0] reference_count,
  input wire logic conv_done,
  input wire logic hires_result_pending_n,
  input wire logic zero_cycles_error,
  input wire logic over_range_error,
  input wire logic under_range_error,
  input wire logic overflow_error
);
  logic [31:0] gap_reg;
  logic seen_reg;
  // low byte read and window length
  wire logic lo_rd = reg_rd_en && reg_addr == HIR_ADDR_RESULT_LOW;
  wire logic [31:0] win = reference_count * HIR_CONV_MUL + HIR_CONV_ADD;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // cycles since last done; slack because error codes finish sooner
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_reg <= '0;
      seen_reg <= 1'b0;
    end else begin
      gap_reg <= conv_done ? '0 : gap_reg + 1;
      seen_reg <= seen_reg | conv_done;
    end
  end
  a_done_pulse: assert property (conv_done |=> !conv_done)
    else $error("done too long");
  a_done_spacing: assert property (conv_done && seen_reg |-> gap_reg + 30 >= win && gap_reg <= win + 30)
    else $error("bad window");
  a_done_pending: assert property (conv_done |-> !hires_result_pending_n)
    else $error("ready not set");
  a_low_read_clears: assert property (lo_rd |=> hires_result_pending_n || conv_done)
    else $error("ready not cleared");
  a_pending_holds: assert property (!hires_result_pending_n && !lo_rd |=> !hires_result_pending_n)
    else $error("ready lost");
  a_flags_on_read: assert property
    (!$stable({zero_cycles_error, over_range_error, under_range_error, overflow_error}) |-> $past(lo_rd))
    else $error("flags moved");
  a_rdata_holds: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("data moved");
  a_unmapped_zero: assert property (reg_rd_en && !(reg_addr inside
    {[HIR_ADDR_OFFSET_LOW:HIR_ADDR_CONFIG], [HIR_ADDR_RESULT_LOW:HIR_ADDR_RESULT_HIGH]})
    |=> reg_rdata == HIR_UNMAPPED_DATA)
    else $error("unmapped data");
  c_done: cover property (conv_done);
  c_low_read: cover property (lo_rd);
  c_overflow: cover property ($rose(overflow_error));
  c_under_range: cover property ($rose(under_range_error));
endmodule
bind hir_result_regs hir_result_checker u_chk (.ref_clk, .sys_rst, .reg_addr, .reg_rd_en, .reg_rdata,
  .reference_count, .conv_done, .hires_result_pending_n, .zero_cycles_error, .over_range_error,
  .under_range_error, .overflow_error);

/* File: bench/hir_host_model.sv */
// host model on the register port
`timescale 1ns/100ps
module hir_host_model import hir_pkg::*; (
  input wire logic ref_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wdata,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rdata
);
  // idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= (a == HIR_ADDR_CONFIG) ? (d & 8'h03) : d;
    reg_wr_en <= 1'b1;
    @(posedge ref_clk);
    // released bus shows the inverse so stale values never pass
    reg_addr <= ~a;
    reg_wdata <= ~d;
    reg_wr_en <= 1'b0;
  endtask
  // data sampled mid-cycle, after the registered read lands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge ref_clk);
    reg_addr <= ~a;
    reg_rd_en <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic rd_result(output logic [23:0] r);
    rd(HIR_ADDR_RESULT_LOW, r[7:0]);
    rd(HIR_ADDR_RESULT_MIDDLE, r[15:8]);
    rd(HIR_ADDR_RESULT_HIGH, r[23:16]);
  endtask
endmodule

/* File: bench/tb.sv */
// self-checking bench for the result register block
`timescale 1ns/100ps
module tb import hir_pkg::*; ;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sensor_edge = 1'b0;
  logic [15:0] reference_count = 16'h0002;
  int sens_cnt = 0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr_en, reg_rd_en, conv_done, hires_result_pending_n;
  logic zero_cycles_error, over_range_error, under_range_error, overflow_error;
  int n_mismatch = 0;
  int samples_checked = 0;
  int per = 0;
  logic [3:0] prev_err = 4'h0;
  wire logic [4:0] stat = {hires_result_pending_n, zero_cycles_error, over_range_error, under_range_error,
    overflow_error};
  hir_result_regs u_dut (.ref_clk, .sys_rst, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata,
    .sensor_edge, .reference_count, .conv_done, .hires_result_pending_n, .zero_cycles_error,
    .over_range_error, .under_range_error, .overflow_error);
  hir_host_model u_host (.ref_clk, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata);
  // clock
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // sensor pulses: per 0 none, otherwise one pulse every per cycles
  always @(posedge ref_clk) begin
    sensor_edge <= (per != 0) && (sens_cnt == 0);
    sens_cnt <= (sens_cnt + 1 >= per) ? 0 : sens_cnt + 1;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d compares %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // bounded wait for a conversion end, returns cycles waited
  task automatic wait_done(output int gap);
    gap = 0;
    do begin
      @(negedge ref_clk);
      gap++;
    end while (conv_done !== 1'b1 && gap < 2000);
    if (gap >= 2000) begin
      n_mismatch++;
      conclude();
    end
  endtask
  // ideal code for n counted edges, clamped at zero
  function automatic logic [23:0] code_of(input int n, input logic [15:0] ofs, input int w);
    longint c;
    c = ((longint'(n) << 24) / w) - longint'(ofs);
    return (c < 0) ? 24'h00_0000 : c[23:0];
  endfunction
  task automatic t_reset_values();
    logic [7:0] d;
    check(stat, 5'h00);
    for (int a = 32'h32; a <= 32'h3A; a++) begin
      u_host.rd(a[7:0], d);
      check(d, HIR_RST_BYTE);
    end
  endtask
  task automatic t_register_access();
    logic [7:0] d;
    u_host.wr(HIR_ADDR_OFFSET_LOW, 8'hA5);
    u_host.wr(HIR_ADDR_OFFSET_HIGH, 8'h5A);
    u_host.wr(HIR_ADDR_RESULT_HIGH, 8'hFF);
    u_host.rd(HIR_ADDR_OFFSET_LOW, d);
    check(d, 8'hA5);
    u_host.rd(HIR_ADDR_OFFSET_HIGH, d);
    check(d, 8'h5A);
    u_host.rd(HIR_ADDR_RESULT_HIGH, d);
    check(d, 8'h00);
  endtask
  // edge count may land either side of the window split, so two codes pass
  task automatic t_measure(input logic [15:0] rc, input logic [1:0] div, input int p, input logic [15:0] ofs,
    input logic [3:0] err);
    int gap;
    int n;
    int win;
    logic [7:0] d;
    logic [23:0] r;
    logic [23:0] e;
    win = int'(rc) * HIR_CONV_MUL + HIR_CONV_ADD;
    per = p;
    // only ever grown, so the running window stretches instead of ending early
    @(posedge ref_clk);
    reference_count <= rc;
    u_host.wr(HIR_ADDR_OFFSET_LOW, ofs[7:0]);
    u_host.wr(HIR_ADDR_OFFSET_HIGH, ofs[15:8]);
    u_host.wr(HIR_ADDR_CONFIG, {6'h00, div});
    wait_done(gap);
    wait_done(gap);
    wait_done(gap);
    check(gap inside {[win - 1:win + 1]}, 1'b1);
    check(stat, {1'b0, prev_err});
    u_host.rd_result(r);
    check(stat, {1'b1, err});
    n = (p == 0) ? 0 : (win / p) >> div;
    e = code_of(n + 1, ofs, win);
    if (r !== e) e = code_of(n, ofs, win);
    if (err != 4'h0) e = 24'h00_0000;
    check(r, e);
    prev_err = err;
    // a newer conversion must not reach the middle byte before the next low read
    wait_done(gap);
    u_host.rd(HIR_ADDR_RESULT_MIDDLE, d);
    check(d, r[15:8]);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset_values();
    t_register_access();
    t_measure(16'h0002, 2'h0, 2, 16'h0000, 4'h0);
    t_measure(16'h0002, 2'h0, 0, 16'h0000, 4'h8);
    t_measure(16'h0002, 2'h1, 2, 16'h0000, 4'h0);
    t_measure(16'h0002, 2'h0, 1, 16'h0000, 4'h1);
    t_measure(16'h0002, 2'h2, 2, 16'h0000, 4'h0);
    t_measure(16'h0002, 2'h3, 2, 16'h1234, 4'h0);
    // long window, sparse edges: the code falls below a large offset
    t_measure(16'h0040, 2'h0, 300, 16'hFFFF, 4'h2);
    conclude();
  end
endmodule
